// ==== atw_params.svh ====
// constants for the arbiter test and withdrawal block
`ifndef ATW_PARAMS_SVH
`define ATW_PARAMS_SVH

// =====================================================================
// register offsets on the 4-bit register port
`define ATW_ADDR_CTRL1     4'h1
`define ATW_ADDR_CTL_THREE 4'h3
`define ATW_ADDR_STATUS    4'h4
`define ATW_ADDR_STATE     4'h5
`define ATW_ADDR_RX_NUM0   4'h8
`define ATW_ADDR_RX_NUM1   4'h9
`define ATW_ADDR_RX_MSG    4'ha

// =====================================================================
// field positions and reset values
`define ATW_CTL_THREE_GO   0
`define ATW_CTL_THREE_TSEL 1
`define ATW_CTL_THREE_RST  8'h00
`define ATW_CTRL1_RST      8'h28
`define ATW_RX_RST         8'h00

// =====================================================================
// counts
`define ATW_ACK_EDGE       2'h2
`define ATW_CS_SAT         2'h3
`define ATW_DIV_FIXED      6'h28
`define ATW_TIMER_LEN      4'h1

`endif

// ==== atw_pkg.sv ====
// types and decode functions for the arbiter test and withdrawal block
`include "atw_params.svh"

package atw_pkg;

    // =================================================================
    // arbitration phases, one-hot
    typedef enum logic [5:0] {
        ATW_PH0 = 6'h01,
        ATW_PH1 = 6'h02,
        ATW_PH2 = 6'h04,
        ATW_PH3 = 6'h08,
        ATW_PH4 = 6'h10,
        ATW_PH5 = 6'h20
    } atw_phase_t;

    // withdrawal sequence of the module side
    typedef enum logic [3:0] {
        ATW_WD_RUN   = 4'h1,
        ATW_WD_DRAIN = 4'h2,
        ATW_WD_HALT  = 4'h4,
        ATW_WD_OFF   = 4'h8
    } atw_wd_t;

    // host register cycle
    typedef enum logic [2:0] {
        ATW_HB_IDLE = 3'h1,
        ATW_HB_WAIT = 3'h2,
        ATW_HB_REC  = 3'h4
    } atw_hbus_t;

    // =================================================================
    // receive registers load from the competition-number port
    function automatic logic atw_is_rx(input logic [3:0] a);
        return (a == `ATW_ADDR_RX_NUM0) || (a == `ATW_ADDR_RX_NUM1) || (a == `ATW_ADDR_RX_MSG);
    endfunction

endpackage

// ==== atw_if.sv ====
// link between the arbitration controller and the module-side logic
`timescale 1ns/1ns

interface atw_if;
    // register port
    logic       csN;
    logic       rwN;
    logic [3:0] addr;
    logic [7:0] dataIn;
    logic [7:0] dataOut;
    logic       dataOe;
    logic       strobeAckN;
    // control from the module side
    logic       haltN;
    logic       pupRstN;
    // arbitration outputs of the controller
    logic       phase0ArbOut;
    logic       phase2ArbOut;
    logic       phase4ArbOut;
    // driven by the world outside both ends
    logic [7:0] competitionNumberPort;
    logic       testClk;

    modport device (
        input  csN, rwN, addr, dataIn, haltN, pupRstN, competitionNumberPort, testClk,
        output dataOut, dataOe, strobeAckN, phase0ArbOut, phase2ArbOut, phase4ArbOut
    );

    modport host (
        output csN, rwN, addr, dataIn, haltN, pupRstN,
        input  dataOut, dataOe, strobeAckN, phase0ArbOut, phase2ArbOut, phase4ArbOut
    );
endinterface

// ==== atw_count_check.sv ====
// timer and divider chain with test clock steering and check bits
`timescale 1ns/1ns

module atw_count_check (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // control
    input  wire logic       testSel,
    input  wire logic       testClk,
    input  wire logic [5:0] divN,
    // results
    output logic            usTick,
    output logic [2:0]      checkBits
);
    logic       tclkQ_r;
    logic [5:0] divCnt_r;
    logic [5:0] div40Cnt_r;
    logic [3:0] timerCnt_r;
    logic       usTick_r;
    logic [2:0] check_r;

    // =================================================================
    // source selection
    // test clock is sampled as a level, so it must run well below clk
    wire testRise  = testClk & ~tclkQ_r;
    wire step      = testSel ? testRise : 1'b1;
    wire [5:0] nTop = (divN == 6'h00) ? 6'h00 : divN - 6'h01;
    wire divNWrap  = step & (divCnt_r >= nTop);
    wire div40Wrap = step & (div40Cnt_r == `ATW_DIV_FIXED - 6'h01);
    // timer runs from the 1 MHz divider, or straight from the test clock
    wire timerStep = testSel ? testRise : divNWrap;
    wire timerWrap = timerStep & (timerCnt_r == `ATW_TIMER_LEN - 4'h1);

    // counters; each check bit toggles when its stage wraps
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tclkQ_r    <= 1'b0;
            divCnt_r   <= 6'h00;
            div40Cnt_r <= 6'h00;
            timerCnt_r <= 4'h0;
            usTick_r   <= 1'b0;
            check_r    <= 3'h0;
        end else begin
            tclkQ_r    <= testClk;
            divCnt_r   <= divNWrap ? 6'h00 : divCnt_r + {5'h00, step};
            div40Cnt_r <= div40Wrap ? 6'h00 : div40Cnt_r + {5'h00, step};
            timerCnt_r <= timerWrap ? 4'h0 : timerCnt_r + {3'h0, timerStep};
            usTick_r   <= timerWrap;
            check_r    <= check_r ^ {timerWrap, div40Wrap, divNWrap};
        end
    end

    assign usTick    = usTick_r;
    assign checkBits = check_r;
endmodule

// ==== atw_device.sv ====
// arbitration controller end: register port, phase tracking, test features
//
// Notes on behaviour
// - withdrawing module first finishes started tasks
// - then it only watches, joins no transactions
// - withdraw by negating phase 0/2/4 output
// - hold off, await phase 0, then reset
// - power-up reset releases all arbitration outputs
// - state register reads the current phase
// - test clock select steers timer and dividers
// - status check bits show timer and dividers
// - receive register writes take competition number
// - that load uses ordinary write cycle timing
// - reading receive register returns stored number
// - acknowledge on third edge, none if short
// - short write latches on chip select release
// - reset clears; release asserts phase 0 output
// - hold-off parks controller in phase 0
`timescale 1ns/1ns
`include "atw_params.svh"

module atw_device (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // link to the module side
    atw_if.device           bus,
    // user-side observation
    output logic [5:0]      phaseNow,
    output logic [7:0]      controlRegThree,
    output logic [2:0]      counterCheckBits
);
    // =================================================================
    // state
    atw_pkg::atw_phase_t phase_r;
    atw_pkg::atw_phase_t phase_nxt;
    logic [1:0] csCnt_r;
    logic       ackN_r;
    logic [3:0] addrQ_r;
    logic [7:0] dataQ_r;
    logic       rwQ_r;
    logic [7:0] ctrl1_r;
    logic [7:0] controlRegThree_r;
    logic [7:0] receivedNumber0_r;
    logic [7:0] receivedNumber1_r;
    logic [7:0] receivedMessageNumber_r;
    logic [7:0] dataOut_r;
    logic       dataOe_r;
    logic       p0_r;
    logic       p2_r;
    logic       p4_r;
    logic       usTick;
    logic [2:0] counterCheckBits_w;

    // =================================================================
    // reset and control decode
    // power-up reset acts like the block reset, both sampled on clk
    wire clearAll  = ~rstn | ~bus.pupRstN;
    wire holdOff   = ~bus.haltN;
    wire csLow     = ~bus.csN;
    wire goBit     = controlRegThree_r[`ATW_CTL_THREE_GO];
    wire testSel   = controlRegThree_r[`ATW_CTL_THREE_TSEL];

    // =================================================================
    // register cycle timing
    // third sampled-low edge gives the acknowledge
    wire ackFire   = csLow & (csCnt_r == `ATW_ACK_EDGE);
    // release before that edge still writes, from the held copy
    wire shortEnd  = ~csLow & (csCnt_r != 2'h0) & (csCnt_r != `ATW_CS_SAT);
    wire shortWr   = shortEnd & ~rwQ_r;
    wire fullWr    = ackFire & ~bus.rwN;
    wire wrNow     = fullWr | shortWr;
    wire [3:0] wrAddr = fullWr ? bus.addr : addrQ_r;
    wire [7:0] portData = fullWr ? bus.dataIn : dataQ_r;
    // receive registers take the competition-number port instead
    wire wrRx      = atw_pkg::atw_is_rx(wrAddr);
    wire [7:0] wrData = wrRx ? bus.competitionNumberPort : portData;

    // write strobes per register
    wire wrCtrl1   = wrNow & (wrAddr == `ATW_ADDR_CTRL1);
    wire wrCtlThree = wrNow & (wrAddr == `ATW_ADDR_CTL_THREE);
    wire wrRx0     = wrNow & (wrAddr == `ATW_ADDR_RX_NUM0);
    wire wrRx1     = wrNow & (wrAddr == `ATW_ADDR_RX_NUM1);
    wire wrRxm     = wrNow & (wrAddr == `ATW_ADDR_RX_MSG);

    // =================================================================
    // read data selection
    wire [2:0] phaseCode =
        {phase_r[4] | phase_r[5], phase_r[2] | phase_r[3], phase_r[1] | phase_r[3] | phase_r[5]};
    wire [7:0] stateRead  = {5'h00, phaseCode};
    wire [7:0] statusRead = {5'h00, counterCheckBits_w};
    wire [7:0] readMux =
        (bus.addr == `ATW_ADDR_CTRL1)     ? ctrl1_r :
        (bus.addr == `ATW_ADDR_CTL_THREE) ? controlRegThree_r :
        (bus.addr == `ATW_ADDR_STATUS)    ? statusRead :
        (bus.addr == `ATW_ADDR_STATE)     ? stateRead :
        (bus.addr == `ATW_ADDR_RX_NUM0)   ? receivedNumber0_r :
        (bus.addr == `ATW_ADDR_RX_NUM1)   ? receivedNumber1_r :
        (bus.addr == `ATW_ADDR_RX_MSG)    ? receivedMessageNumber_r :
                                            8'h00;
    wire readCyc = csLow & bus.rwN;

    // =================================================================
    // timer and divider chain
    atw_count_check u_check (
        .clk       (clk),
        .rstn      (~clearAll),
        .testSel   (testSel),
        .testClk   (bus.testClk),
        .divN      (ctrl1_r[5:0]),
        .usTick    (usTick),
        .checkBits (counterCheckBits_w)
    );

    // =================================================================
    // phase sequencing, one step per microsecond tick
    // hold-off only bites in phase 0, so a running cycle still completes
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            atw_pkg::ATW_PH0: begin
                if (usTick && !holdOff) begin
                    phase_nxt = atw_pkg::ATW_PH1;
                end
            end
            atw_pkg::ATW_PH1: begin
                if (usTick) begin
                    phase_nxt = atw_pkg::ATW_PH2;
                end
            end
            atw_pkg::ATW_PH2: begin
                if (usTick) begin
                    phase_nxt = atw_pkg::ATW_PH3;
                end
            end
            atw_pkg::ATW_PH3: begin
                if (usTick) begin
                    phase_nxt = atw_pkg::ATW_PH4;
                end
            end
            atw_pkg::ATW_PH4: begin
                if (usTick) begin
                    phase_nxt = atw_pkg::ATW_PH5;
                end
            end
            atw_pkg::ATW_PH5: begin
                if (usTick) begin
                    phase_nxt = atw_pkg::ATW_PH0;
                end
            end
            default: begin
                phase_nxt = atw_pkg::ATW_PH0;
            end
        endcase
    end

    // phase register and arbitration outputs
    // phase 0 output needs no go bit so a freshly reset part is aligned
    always_ff @(posedge clk) begin
        if (clearAll) begin
            phase_r <= atw_pkg::ATW_PH0;
            p0_r    <= 1'b0;
            p2_r    <= 1'b0;
            p4_r    <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            p0_r    <= (phase_nxt == atw_pkg::ATW_PH0);
            p2_r    <= goBit & (phase_nxt == atw_pkg::ATW_PH2);
            p4_r    <= goBit & (phase_nxt == atw_pkg::ATW_PH4);
        end
    end

    // =================================================================
    // chip select tracking and acknowledge
    // count saturates so a long cycle keeps the acknowledge low
    always_ff @(posedge clk) begin
        if (clearAll) begin
            csCnt_r <= 2'h0;
            ackN_r  <= 1'b1;
            addrQ_r <= 4'h0;
            dataQ_r <= 8'h00;
            rwQ_r   <= 1'b1;
        end else begin
            csCnt_r <= !csLow ? 2'h0 : (csCnt_r == `ATW_CS_SAT) ? csCnt_r : csCnt_r + 2'h1;
            ackN_r  <= !csLow ? 1'b1 : (ackFire ? 1'b0 : ackN_r);
            if (csLow) begin
                addrQ_r <= bus.addr;
                dataQ_r <= bus.dataIn;
                rwQ_r   <= bus.rwN;
            end
        end
    end

    // register file; defaults come back on either reset
    always_ff @(posedge clk) begin
        if (clearAll) begin
            ctrl1_r                 <= `ATW_CTRL1_RST;
            controlRegThree_r       <= `ATW_CTL_THREE_RST;
            receivedNumber0_r       <= `ATW_RX_RST;
            receivedNumber1_r       <= `ATW_RX_RST;
            receivedMessageNumber_r <= `ATW_RX_RST;
        end else begin
            if (wrCtrl1) begin
                ctrl1_r <= wrData;
            end
            if (wrCtlThree) begin
                controlRegThree_r <= wrData;
            end
            if (wrRx0) begin
                receivedNumber0_r <= wrData;
            end
            if (wrRx1) begin
                receivedNumber1_r <= wrData;
            end
            if (wrRxm) begin
                receivedMessageNumber_r <= wrData;
            end
        end
    end

    // read path, registered so the data port comes from a flop
    always_ff @(posedge clk) begin
        if (clearAll) begin
            dataOut_r <= 8'h00;
            dataOe_r  <= 1'b0;
        end else begin
            dataOut_r <= readCyc ? readMux : 8'h00;
            dataOe_r  <= readCyc;
        end
    end

    // =================================================================
    // outputs
    assign bus.strobeAckN   = ackN_r;
    assign bus.dataOut      = dataOut_r;
    assign bus.dataOe       = dataOe_r;
    assign bus.phase0ArbOut = p0_r;
    assign bus.phase2ArbOut = p2_r;
    assign bus.phase4ArbOut = p4_r;
    assign phaseNow         = phase_r;
    assign controlRegThree  = controlRegThree_r;
    assign counterCheckBits = counterCheckBits_w;
endmodule

// ==== atw_host.sv ====
// module-side end: register cycles and the live withdrawal sequence
`timescale 1ns/1ns

module atw_host (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // link to the controller
    atw_if.host             bus,
    // register requests
    input  wire logic       reqValid,
    input  wire logic       reqWrite,
    input  wire logic [3:0] reqAddr,
    input  wire logic [7:0] reqWdata,
    output logic            reqReady,
    output logic            rspValid,
    output logic [7:0]      rspData,
    // withdrawal
    input  wire logic       withdrawReq,
    input  wire logic       tasksBusy,
    output logic            bystander,
    output logic            withdrawn
);
    atw_pkg::atw_hbus_t hb_r;
    atw_pkg::atw_wd_t   wd_r;
    logic       csN_r;
    logic       rwN_r;
    logic [3:0] addr_r;
    logic [7:0] wdata_r;
    logic       haltN_r;
    logic       pupRstN_r;
    logic       rspValid_r;
    logic [7:0] rspData_r;

    // =================================================================
    // decode
    // no new cycle once withdrawal has begun
    wire open    = (wd_r == atw_pkg::ATW_WD_RUN) & ~withdrawReq;
    wire idle    = (hb_r == atw_pkg::ATW_HB_IDLE);
    wire take    = idle & open & reqValid;
    wire acked   = (hb_r == atw_pkg::ATW_HB_WAIT) & ~bus.strobeAckN;
    wire recDone = (hb_r == atw_pkg::ATW_HB_REC) & bus.strobeAckN;
    wire drained = (wd_r == atw_pkg::ATW_WD_DRAIN) & ~tasksBusy & idle;
    wire atPh0   = (wd_r == atw_pkg::ATW_WD_HALT) & bus.phase0ArbOut;

    // register cycle: hold select until acknowledged, then wait release
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hb_r       <= atw_pkg::ATW_HB_IDLE;
            csN_r      <= 1'b1;
            rwN_r      <= 1'b1;
            addr_r     <= 4'h0;
            wdata_r    <= 8'h00;
            rspValid_r <= 1'b0;
            rspData_r  <= 8'h00;
        end else begin
            rspValid_r <= acked;
            if (take) begin
                hb_r    <= atw_pkg::ATW_HB_WAIT;
                csN_r   <= 1'b0;
                rwN_r   <= ~reqWrite;
                addr_r  <= reqAddr;
                wdata_r <= reqWdata;
            end else if (acked) begin
                hb_r      <= atw_pkg::ATW_HB_REC;
                csN_r     <= 1'b1;
                rspData_r <= rwN_r ? bus.dataOut : 8'h00;
            end else if (recDone) begin
                hb_r  <= atw_pkg::ATW_HB_IDLE;
                rwN_r <= 1'b1;
            end
        end
    end

    // withdrawal: drain, hold off, see phase 0, then power-up reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wd_r      <= atw_pkg::ATW_WD_RUN;
            haltN_r   <= 1'b1;
            pupRstN_r <= 1'b1;
        end else begin
            unique case (wd_r)
                atw_pkg::ATW_WD_RUN: begin
                    if (withdrawReq) begin
                        wd_r <= atw_pkg::ATW_WD_DRAIN;
                    end
                end
                atw_pkg::ATW_WD_DRAIN: begin
                    if (drained) begin
                        wd_r    <= atw_pkg::ATW_WD_HALT;
                        haltN_r <= 1'b0;
                    end
                end
                atw_pkg::ATW_WD_HALT: begin
                    if (atPh0) begin
                        wd_r      <= atw_pkg::ATW_WD_OFF;
                        pupRstN_r <= 1'b0;
                    end
                end
                atw_pkg::ATW_WD_OFF: begin
                    wd_r <= atw_pkg::ATW_WD_OFF;
                end
                default: begin
                    wd_r <= atw_pkg::ATW_WD_RUN;
                end
            endcase
        end
    end

    // =================================================================
    // outputs
    assign bus.csN     = csN_r;
    assign bus.rwN     = rwN_r;
    assign bus.addr    = addr_r;
    assign bus.dataIn  = wdata_r;
    assign bus.haltN   = haltN_r;
    assign bus.pupRstN = pupRstN_r;
    assign reqReady    = idle & open;
    assign rspValid    = rspValid_r;
    assign rspData     = rspData_r;
    assign bystander   = (wd_r != atw_pkg::ATW_WD_RUN);
    assign withdrawn   = (wd_r == atw_pkg::ATW_WD_OFF);
endmodule

// ==== atw_link_asserts.sv ====
// concurrent checks on the link between controller and module side
`timescale 1ns/1ns

module atw_link_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // link signals
    input wire logic csN,
    input wire logic rwN,
    input wire logic dataOe,
    input wire logic strobeAckN,
    input wire logic haltN,
    input wire logic pupRstN,
    input wire logic phase0ArbOut,
    input wire logic phase2ArbOut,
    input wire logic phase4ArbOut
);
    // =================================================================
    // power-up reset clears the controller too, so bus rules pause then
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !pupRstN);

    ack_third_edge_a: assert property (!csN [*3] |=> !strobeAckN)
        else $error("no acknowledge after three select edges");
    no_short_ack_a: assert property ($fell(strobeAckN) |->
        !$past(csN, 1) && !$past(csN, 2) && !$past(csN, 3))
        else $error("acknowledge after a short select");
    ack_release_a: assert property (!strobeAckN && csN |=> strobeAckN)
        else $error("acknowledge held after select released");
    read_drive_a: assert property (!csN && rwN && !strobeAckN |-> dataOe)
        else $error("read acknowledged without data driven");
    halt_park_a: assert property (!haltN && phase0ArbOut |=> phase0ArbOut)
        else $error("left phase 0 while held off");
    phase_excl_a: assert property (!(phase0ArbOut && (phase2ArbOut || phase4ArbOut)))
        else $error("phase 0 output beside a later phase output");
    halt_idle_a: assert property (!haltN |-> csN)
        else $error("register cycle while held off");
    // these watch the power-up reset and the rstn release, so only rstn stops them
    pup_release_a: assert property (disable iff (!rstn)
        !pupRstN |=> !phase0ArbOut && !phase2ArbOut && !phase4ArbOut)
        else $error("arbitration output during power-up reset");
    pup_order_a: assert property (disable iff (!rstn)
        $fell(pupRstN) |-> $past(phase0ArbOut) && !haltN)
        else $error("power-up reset before hold-off in phase 0");
    rst_phase0_a: assert property (disable iff (!rstn)
        $rose(rstn) |=> phase0ArbOut)
        else $error("phase 0 output missing after reset");
endmodule

// ==== tb.sv ====
// self-checking bench joining both ends of the arbiter link
`timescale 1ns/1ns

module tb;
    // =================================================================
    // signals
    logic       clk;
    logic       rstn;
    logic       reqValid;
    logic       reqWrite;
    logic [3:0] reqAddr;
    logic [7:0] reqWdata;
    logic       reqReady;
    logic       rspValid;
    logic [7:0] rspData;
    logic       withdrawReq;
    logic       tasksBusy;
    logic       bystander;
    logic       withdrawn;
    logic [7:0] got;
    logic [7:0] s0;
    logic [7:0] c0;
    logic [5:0] phaseNow;
    logic [7:0] controlRegThree;
    logic [2:0] counterCheckBits;
    int         n;
    int         num_errors;
    int         total_checks;
    // a row: write flag, address, data byte, expected read or port value
    typedef struct {
        logic       w;
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } atw_row_t;
    atw_row_t rows [13] = '{'{1'b0, 4'h1, 8'h00, 8'h28}, '{1'b0, 4'h3, 8'h00, 8'h00},
        '{1'b1, 4'h8, 8'h11, 8'ha5}, '{1'b1, 4'h9, 8'h22, 8'h5a}, '{1'b1, 4'ha, 8'h33, 8'hc3},
        '{1'b0, 4'h8, 8'h00, 8'ha5}, '{1'b0, 4'h9, 8'h00, 8'h5a}, '{1'b0, 4'ha, 8'h00, 8'hc3},
        '{1'b0, 4'hf, 8'h00, 8'h00}, '{1'b1, 4'h1, 8'h01, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h01},
        '{1'b1, 4'h3, 8'h03, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h03}};

    // =================================================================
    // both ends and the checker
    atw_if linkIf ();
    atw_device atw_device_inst (.clk(clk), .rstn(rstn), .bus(linkIf), .phaseNow(phaseNow),
        .controlRegThree(controlRegThree), .counterCheckBits(counterCheckBits));
    atw_host atw_host_inst (.clk(clk), .rstn(rstn), .bus(linkIf), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .withdrawReq(withdrawReq),
        .tasksBusy(tasksBusy), .bystander(bystander), .withdrawn(withdrawn));
    atw_link_asserts atw_link_asserts_inst (.clk(clk), .rstn(rstn), .csN(linkIf.csN),
        .rwN(linkIf.rwN), .dataOe(linkIf.dataOe), .strobeAckN(linkIf.strobeAckN),
        .haltN(linkIf.haltN), .pupRstN(linkIf.pupRstN), .phase0ArbOut(linkIf.phase0ArbOut),
        .phase2ArbOut(linkIf.phase2ArbOut), .phase4ArbOut(linkIf.phase4ArbOut));

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // =================================================================
    // compares, register cycle and verdict
    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t byte %h want %h", $time, g, e);
        end
    endtask
    task automatic check1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t flag %b want %b", $time, g, e);
        end
    endtask
    // one slow test clock period; it is sampled as a level, so keep it long
    task automatic tclk_rise();
        @(posedge clk);
        linkIf.testClk <= 1'b1;
        repeat (3) @(posedge clk);
        linkIf.testClk <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // ready is sampled at the falling edge, away from the updating edge
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (reqReady !== 1'b1 && k < 50);
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr  <= a;
        reqWdata <= d;
        @(posedge clk);
        reqValid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rspValid !== 1'b1 && k < 50);
        check1(rspValid, 1'b1);
        got = rspData;
    endtask
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 4'h0;
        reqWdata = 8'h00;
        withdrawReq = 1'b0;
        tasksBusy = 1'b0;
        linkIf.competitionNumberPort = 8'h00;
        linkIf.testClk = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check1(linkIf.strobeAckN, 1'b1);
        check1(linkIf.phase0ArbOut | linkIf.phase2ArbOut | linkIf.phase4ArbOut, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        // port value differs from the data byte, so a wrong source shows
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            linkIf.competitionNumberPort <= rows[i].w ? rows[i].e : 8'h00;
            reg_op(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check8(got, rows[i].e);
        end
        // test clock held still freezes phases; one rise advances one
        reg_op(1'b0, 4'h5, 8'h00);
        s0 = got;
        check8({2'h0, phaseNow}, 8'h01 << s0);
        check1(linkIf.phase0ArbOut, s0 == 8'h00);
        check1(linkIf.phase2ArbOut, s0 == 8'h02);
        check1(linkIf.phase4ArbOut, s0 == 8'h04);
        check8(controlRegThree, 8'h03);
        reg_op(1'b0, 4'h4, 8'h00);
        c0 = got;
        tclk_rise();
        reg_op(1'b0, 4'h5, 8'h00);
        check8(got, (s0 == 8'h05) ? 8'h00 : s0 + 8'h01);
        // forty rises in all: div40 wraps once, the others toggle evenly
        repeat (39) tclk_rise();
        reg_op(1'b0, 4'h4, 8'h00);
        check8(got, c0 ^ 8'h02);
        check8({5'h00, counterCheckBits}, c0 ^ 8'h02);
        reg_op(1'b1, 4'h3, 8'h00);
        // withdrawal waits while tasks are still busy
        @(posedge clk);
        tasksBusy <= 1'b1;
        withdrawReq <= 1'b1;
        repeat (20) @(negedge clk);
        check1(bystander, 1'b1);
        check1(linkIf.haltN, 1'b1);
        check1(reqReady, 1'b0);
        @(posedge clk);
        tasksBusy <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (withdrawn !== 1'b1 && n < 200);
        check1(withdrawn, 1'b1);
        repeat (2) @(negedge clk);
        check1(linkIf.phase0ArbOut | linkIf.phase2ArbOut | linkIf.phase4ArbOut, 1'b0);
        // second reset mid-run: both ends restart, phase 0 output returns
        @(posedge clk);
        withdrawReq <= 1'b0;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(negedge clk);
        check1(linkIf.phase0ArbOut, 1'b1);
        check1(withdrawn | ~linkIf.pupRstN | ~linkIf.haltN, 1'b0);
        reg_op(1'b0, 4'h1, 8'h00);
        check8(got, 8'h28);
        test_done();
    end
endmodule
